/* File: design/evm_exception_vector_mapper.v */
// Exception vector mapper: vector number to table fetch and handler entry.
`timescale 1ns/1ps
`include "evm_regs.vh"

module evm_exception_vector_mapper (
    input wire ref_clk,
    input wire sys_rst,
    input wire excReq,
    input wire [2:0] excSource,
    input wire irqAutovector,
    input wire [2:0] irqLevel,
    input wire irqSpurious,
    input wire irqUninit,
    input wire [7:0] extVectorNum,
    input wire busAck,
    input wire [15:0] busRdata,
    output reg busReq,
    output reg [19:0] busAddr,
    output reg busProgSpace,
    output reg busy,
    output reg handlerStart,
    output reg resetLoaded,
    output reg [15:0] pcOut,
    output reg [3:0] programBankField,
    output reg [3:0] stackBankField,
    output reg [3:0] zIndexBankField,
    output reg [15:0] spOut,
    output reg [15:0] zIndexRegister,
    output reg [7:0] vecNumOut,
    output reg reservedFlag,
    output reg userFlag
);

    ////////////////////////////////////////////////////////////////////////
    // States and local storage.
    localparam ST_IDLE = 2'h0;
    localparam ST_FETCH = 2'h1;
    localparam ST_DONE = 2'h2;

    reg [1:0] state_reg;
    reg [1:0] state_next;
    reg [1:0] wordIdx_reg;
    reg [1:0] wordIdx_next;
    reg resetSeq_reg;
    reg resetSeq_next;
    reg startPending_reg;
    reg startPending_next;
    reg [7:0] vecNum_reg;
    reg [7:0] vecNum_next;

    wire [7:0] decVecNum;
    wire decIsReset;
    wire decReserved;
    wire decUser;
    wire wordTaken;

    reg busReq_next;
    reg [19:0] busAddr_next;
    reg busProgSpace_next;
    reg busy_next;
    reg handlerStart_next;
    reg resetLoaded_next;
    reg [15:0] pcOut_next;
    reg [3:0] programBankField_next;
    reg [3:0] stackBankField_next;
    reg [3:0] zIndexBankField_next;
    reg [15:0] spOut_next;
    reg [15:0] zIndexRegister_next;
    reg [7:0] vecNumOut_next;
    reg reservedFlag_next;
    reg userFlag_next;

    ////////////////////////////////////////////////////////////////////////
    // Table address: number shifted left once, upper bank bits zero.
    function [19:0] evmVectorAddr;
        input [7:0] num;
        begin
            evmVectorAddr = {11'h000, num, 1'b0};
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Vector number source selection.
    evm_vector_decode uDecode (
        .excSource(excSource),
        .irqAutovector(irqAutovector),
        .irqLevel(irqLevel),
        .irqSpurious(irqSpurious),
        .irqUninit(irqUninit),
        .extVectorNum(extVectorNum),
        .vecNum(decVecNum),
        .isReset(decIsReset),
        .reservedVec(decReserved),
        .userVec(decUser)
    );

    assign wordTaken = busReq && busAck;

    ////////////////////////////////////////////////////////////////////////
    // Sequencer next-state logic.
    always @* begin
        state_next = state_reg;
        wordIdx_next = wordIdx_reg;
        resetSeq_next = resetSeq_reg;
        startPending_next = startPending_reg;
        vecNum_next = vecNum_reg;
        case (state_reg)
            ST_IDLE: begin
                if (startPending_reg) begin
                    state_next = ST_FETCH;
                    resetSeq_next = 1'b1;
                    wordIdx_next = `EVM_RST_WORD_FIELDS;
                    vecNum_next = `EVM_VEC_RESET;
                    startPending_next = 1'b0;
                end else if (excReq) begin
                    state_next = ST_FETCH;
                    resetSeq_next = decIsReset;
                    wordIdx_next = `EVM_RST_WORD_FIELDS;
                    vecNum_next = decVecNum;
                end
            end
            ST_FETCH: begin
                if (wordTaken) begin
                    if (resetSeq_reg && wordIdx_reg != `EVM_RST_WORD_LAST) begin
                        wordIdx_next = wordIdx_reg + 2'h1;
                    end else begin
                        state_next = ST_DONE;
                    end
                end
            end
            ST_DONE: begin
                state_next = ST_IDLE;
            end
            default: begin
                state_next = ST_IDLE;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // Sequencer registers.
    always @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            state_reg <= ST_IDLE;
            wordIdx_reg <= 2'h0;
            resetSeq_reg <= 1'b0;
            startPending_reg <= 1'b1;
            vecNum_reg <= 8'h00;
        end else begin
            state_reg <= state_next;
            wordIdx_reg <= wordIdx_next;
            resetSeq_reg <= resetSeq_next;
            startPending_reg <= startPending_next;
            vecNum_reg <= vecNum_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Table fetch port next values.
    always @* begin
        busReq_next = 1'b0;
        busAddr_next = busAddr;
        busProgSpace_next = 1'b0;
        if (state_next == ST_FETCH) begin
            busReq_next = 1'b1;
            if (resetSeq_next) begin
                busAddr_next = evmVectorAddr({6'h00, wordIdx_next});
                busProgSpace_next = 1'b1;
            end else begin
                busAddr_next = evmVectorAddr(vecNum_next);
                busProgSpace_next = 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Table fetch port registers.
    always @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            busReq <= 1'b0;
            busAddr <= 20'h00000;
            busProgSpace <= 1'b0;
        end else begin
            busReq <= busReq_next;
            busAddr <= busAddr_next;
            busProgSpace <= busProgSpace_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Loading of processor state from the fetched words.
    always @* begin
        pcOut_next = pcOut;
        programBankField_next = programBankField;
        stackBankField_next = stackBankField;
        zIndexBankField_next = zIndexBankField;
        spOut_next = spOut;
        zIndexRegister_next = zIndexRegister;
        if (wordTaken && resetSeq_reg) begin
            case (wordIdx_reg)
                `EVM_RST_WORD_FIELDS: begin
                    zIndexBankField_next =
                        busRdata[`EVM_ZK_HI:`EVM_ZK_LO];
                    stackBankField_next =
                        busRdata[`EVM_SK_HI:`EVM_SK_LO];
                    programBankField_next =
                        busRdata[`EVM_PK_HI:`EVM_PK_LO];
                end
                `EVM_RST_WORD_PC: pcOut_next = busRdata;
                `EVM_RST_WORD_SP: spOut_next = busRdata;
                `EVM_RST_WORD_ZIDX: zIndexRegister_next = busRdata;
                default: pcOut_next = pcOut;
            endcase
        end else if (wordTaken) begin
            pcOut_next = busRdata;
            programBankField_next = `EVM_BANK_ZERO;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Processor state registers.
    always @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            pcOut <= `EVM_PC_RESET;
            programBankField <= `EVM_BANK_ZERO;
            stackBankField <= `EVM_BANK_ZERO;
            zIndexBankField <= `EVM_BANK_ZERO;
            spOut <= 16'h0000;
            zIndexRegister <= 16'h0000;
        end else begin
            pcOut <= pcOut_next;
            programBankField <= programBankField_next;
            stackBankField <= stackBankField_next;
            zIndexBankField <= zIndexBankField_next;
            spOut <= spOut_next;
            zIndexRegister <= zIndexRegister_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Status and completion strobes.
    always @* begin
        busy_next = (state_next != ST_IDLE);
        handlerStart_next = (state_next == ST_DONE);
        resetLoaded_next = (state_next == ST_DONE) && resetSeq_reg;
        vecNumOut_next = vecNumOut;
        reservedFlag_next = reservedFlag;
        userFlag_next = userFlag;
        if (state_reg == ST_IDLE && !startPending_reg && excReq) begin
            vecNumOut_next = decVecNum;
            reservedFlag_next = decReserved;
            userFlag_next = decUser;
        end else if (state_reg == ST_IDLE && startPending_reg) begin
            vecNumOut_next = `EVM_VEC_RESET;
            reservedFlag_next = 1'b0;
            userFlag_next = 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Status registers.
    always @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            busy <= 1'b1;
            handlerStart <= 1'b0;
            resetLoaded <= 1'b0;
            vecNumOut <= 8'h00;
            reservedFlag <= 1'b0;
            userFlag <= 1'b0;
        end else begin
            busy <= busy_next;
            handlerStart <= handlerStart_next;
            resetLoaded <= resetLoaded_next;
            vecNumOut <= vecNumOut_next;
            reservedFlag <= reservedFlag_next;
            userFlag <= userFlag_next;
        end
    end

endmodule

/* File: design/evm_regs.vh */
// Constants shared by the exception vector mapper files.
`ifndef EVM_REGS_VH
`define EVM_REGS_VH

`define EVM_VEC_W 8
`define EVM_ADDR_W 20
`define EVM_WORD_W 16
`define EVM_SRC_W 3
`define EVM_TABLE_BYTES 10'h200
`define EVM_PREDEF_COUNT 8'h34
`define EVM_USER_COUNT 8'hC8

`define EVM_SRC_RESET 3'h0
`define EVM_SRC_BREAKPOINT 3'h1
`define EVM_SRC_BUS_ERROR 3'h2
`define EVM_SRC_SOFT_INT 3'h3
`define EVM_SRC_ILLEGAL 3'h4
`define EVM_SRC_DIV_ZERO 3'h5
`define EVM_SRC_INTERRUPT 3'h6

`define EVM_VEC_RESET 8'h00
`define EVM_VEC_BREAKPOINT 8'h04
`define EVM_VEC_BUS_ERROR 8'h05
`define EVM_VEC_SOFT_INT 8'h06
`define EVM_VEC_ILLEGAL 8'h07
`define EVM_VEC_DIV_ZERO 8'h08
`define EVM_VEC_RSV_A_LO 8'h09
`define EVM_VEC_RSV_A_HI 8'h0E
`define EVM_VEC_UNINIT 8'h0F
`define EVM_VEC_RSV_B 8'h10
`define EVM_VEC_AUTO_BASE 8'h10
`define EVM_VEC_SPURIOUS 8'h18
`define EVM_VEC_RSV_C_LO 8'h19
`define EVM_VEC_RSV_C_HI 8'h37
`define EVM_VEC_USER_LO 8'h38

`define EVM_RST_WORD_FIELDS 2'h0
`define EVM_RST_WORD_PC 2'h1
`define EVM_RST_WORD_SP 2'h2
`define EVM_RST_WORD_ZIDX 2'h3
`define EVM_RST_WORD_LAST 2'h3

`define EVM_ZK_HI 11
`define EVM_ZK_LO 8
`define EVM_SK_HI 7
`define EVM_SK_LO 4
`define EVM_PK_HI 3
`define EVM_PK_LO 0

`define EVM_PC_RESET 16'h0000
`define EVM_BANK_ZERO 4'h0

`endif

/* File: design/evm_vector_decode.v */
// Vector number selection and classification for the exception mapper.
`timescale 1ns/1ps
`include "evm_regs.vh"

module evm_vector_decode (
    input wire [2:0] excSource,
    input wire irqAutovector,
    input wire [2:0] irqLevel,
    input wire irqSpurious,
    input wire irqUninit,
    input wire [7:0] extVectorNum,
    output reg [7:0] vecNum,
    output reg isReset,
    output reg reservedVec,
    output reg userVec
);

    ////////////////////////////////////////////////////////////////////////
    // Internal sources have fixed numbers; interrupts may take external.
    always @* begin
        isReset = 1'b0;
        case (excSource)
            `EVM_SRC_RESET: begin
                vecNum = `EVM_VEC_RESET;
                isReset = 1'b1;
            end
            `EVM_SRC_BREAKPOINT: vecNum = `EVM_VEC_BREAKPOINT;
            `EVM_SRC_BUS_ERROR: vecNum = `EVM_VEC_BUS_ERROR;
            `EVM_SRC_SOFT_INT: vecNum = `EVM_VEC_SOFT_INT;
            `EVM_SRC_ILLEGAL: vecNum = `EVM_VEC_ILLEGAL;
            `EVM_SRC_DIV_ZERO: vecNum = `EVM_VEC_DIV_ZERO;
            `EVM_SRC_INTERRUPT: begin
                if (irqSpurious) begin
                    vecNum = `EVM_VEC_SPURIOUS;
                end else if (irqUninit) begin
                    vecNum = `EVM_VEC_UNINIT;
                end else if (irqAutovector && irqLevel != 3'h0) begin
                    vecNum = `EVM_VEC_AUTO_BASE + {5'h00, irqLevel};
                end else if (irqAutovector) begin
                    vecNum = `EVM_VEC_SPURIOUS;
                end else begin
                    vecNum = extVectorNum;
                end
            end
            default: vecNum = `EVM_VEC_ILLEGAL;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // Reserved and user-defined ranges of the table.
    always @* begin
        reservedVec = 1'b0;
        userVec = 1'b0;
        if (!isReset && vecNum < `EVM_VEC_BREAKPOINT) begin
            reservedVec = 1'b1;
        end
        if (vecNum >= `EVM_VEC_RSV_A_LO && vecNum <= `EVM_VEC_RSV_A_HI) begin
            reservedVec = 1'b1;
        end
        if (vecNum == `EVM_VEC_RSV_B) begin
            reservedVec = 1'b1;
        end
        if (vecNum >= `EVM_VEC_RSV_C_LO && vecNum <= `EVM_VEC_RSV_C_HI) begin
            reservedVec = 1'b1;
        end
        if (vecNum >= `EVM_VEC_USER_LO) begin
            userVec = 1'b1;
        end
    end

endmodule

/* File: verif/evm_table_model.sv */
// Vector table memory model answering the mapper's table reads.
`timescale 1ns/1ps
module evm_table_model (
    input wire ref_clk,
    input wire sys_rst,
    input wire busReq,
    input wire [19:0] busAddr,
    input wire busProgSpace,
    input wire [1:0] ackDelay,
    output reg busAck,
    output reg [15:0] busRdata
);
    reg [1:0] waitCnt;
    // Table content is a fixed pattern of address and space.
    function [15:0] mem_word(input [19:0] a, input p);
        mem_word = {a[7:0] ^ 8'h5A, a[8:1]} ^ (p ? 16'hF00F : 16'h0000);
    endfunction
    ////////////////////////////////////////////////////////////////////
    // Data shows the inverse of its last value outside an answer.
    always @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            busAck <= 1'h0;
            busRdata <= 16'h0000;
            waitCnt <= 2'h0;
        end else if (busAck || !busReq) begin
            busAck <= 1'h0;
            busRdata <= ~busRdata;
            waitCnt <= ackDelay;
        end else if (waitCnt != 2'h0) begin
            waitCnt <= waitCnt - 2'h1;
            busRdata <= ~busRdata;
        end else begin
            busAck <= 1'h1;
            busRdata <= mem_word(busAddr, busProgSpace);
        end
    end
endmodule

/* File: verif/evm_mapper_checker.sv */
// Concurrent checks on the exception vector mapper ports.
`timescale 1ns/1ps
module evm_mapper_checker (
    input wire ref_clk,
    input wire sys_rst,
    input wire busAck,
    input wire [15:0] busRdata,
    input wire busReq,
    input wire [19:0] busAddr,
    input wire busProgSpace,
    input wire busy,
    input wire handlerStart,
    input wire resetLoaded,
    input wire [15:0] pcOut,
    input wire [3:0] programBankField,
    input wire [15:0] zIndexRegister,
    input wire [7:0] vecNumOut,
    input wire reservedFlag,
    input wire userFlag
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (sys_rst);
    function automatic logic rsv(input [7:0] v);
        rsv = (v <= 8'h03) || (v >= 8'h19 && v <= 8'h37)
            || (v >= 8'h09 && v <= 8'h10 && v != 8'h0F);
    endfunction
    wire take = busReq && busAck;
    ////////////////////////////////////////////////////////////////////
    a_fetch_aligned: assert property (busReq |-> busAddr[0] == 1'h0
        && busAddr[19:9] == 11'h000) else $error("fetch outside table");
    a_req_held: assert property (busReq && !busAck |=> busReq
        && $stable(busAddr) && $stable(busProgSpace)) else $error("req drop");
    a_data_space: assert property (busReq && vecNumOut != 8'h00
        |-> !busProgSpace) else $error("vector not in data space");
    a_prog_window: assert property (busReq && busProgSpace
        |-> busAddr < 20'h00008) else $error("reset word out of range");
    a_table_addr: assert property (busReq && !busProgSpace
        |-> busAddr == {11'h000, vecNumOut, 1'h0}) else $error("bad addr");
    a_user_flag: assert property (busReq && !busProgSpace
        |-> userFlag == (vecNumOut >= 8'h38)) else $error("user flag");
    a_reserved_flag: assert property (busReq && !busProgSpace
        |-> reservedFlag == rsv(vecNumOut)) else $error("reserved flag");
    a_handler_pc: assert property (take && !busProgSpace
        |=> handlerStart && pcOut == $past(busRdata)
        && programBankField == 4'h0) else $error("pc load");
    a_reset_order: assert property (take && busProgSpace
        && busAddr[2:1] != 2'h3 |=> busReq && busProgSpace
        && busAddr == $past(busAddr) + 20'h2) else $error("reset order");
    a_reset_done: assert property (take && busProgSpace
        && busAddr[2:1] == 2'h3 |=> handlerStart && resetLoaded
        && zIndexRegister == $past(busRdata)) else $error("z load");
    a_busy_drop: assert property (handlerStart
        |=> !busy && !handlerStart) else $error("busy after handler");
    cover property (take && busProgSpace);
    cover property (take && userFlag);
    cover property (handlerStart && !resetLoaded);
endmodule
bind evm_exception_vector_mapper evm_mapper_checker chk (.ref_clk,
    .sys_rst, .busAck, .busRdata, .busReq, .busAddr, .busProgSpace, .busy,
    .handlerStart, .resetLoaded, .pcOut, .programBankField, .zIndexRegister,
    .vecNumOut, .reservedFlag, .userFlag);

/* File: verif/evm_exception_vector_mapper_test.sv */
// Self-checking testbench of the exception vector mapper.
`timescale 1ns/1ps
module evm_exception_vector_mapper_test;
    reg ref_clk, sys_rst, excReq, irqAutovector, irqSpurious, irqUninit;
    reg [2:0] excSource, irqLevel;
    reg [7:0] extVectorNum;
    reg [1:0] ackDelay;
    wire busAck, busReq, busProgSpace, busy, handlerStart, resetLoaded;
    wire [15:0] busRdata, pcOut, spOut, zIndexRegister;
    wire [19:0] busAddr;
    wire [3:0] programBankField, stackBankField, zIndexBankField;
    wire [7:0] vecNumOut;
    wire reservedFlag, userFlag;
    integer n_mismatch, cmp_count, i;
    reg [71:0] corners = 72'h01090E10193738FF00;
    evm_exception_vector_mapper uut (.ref_clk, .sys_rst, .excReq,
        .excSource, .irqAutovector, .irqLevel, .irqSpurious, .irqUninit,
        .extVectorNum, .busAck, .busRdata, .busReq, .busAddr, .busProgSpace,
        .busy, .handlerStart, .resetLoaded, .pcOut, .programBankField,
        .stackBankField, .zIndexBankField, .spOut, .zIndexRegister,
        .vecNumOut, .reservedFlag, .userFlag);
    evm_table_model tbl (.ref_clk, .sys_rst, .busReq, .busAddr,
        .busProgSpace, .ackDelay, .busAck, .busRdata);
    ////////////////////////////////////////////////////////////////////
    task chkv(input [15:0] g, input [15:0] e);
        begin
            cmp_count = cmp_count + 1;
            if (g !== e) begin
                n_mismatch = n_mismatch + 1;
                $display("Error at %0t ns: got %h expected %h", $time, g, e);
            end
        end
    endtask
    task chkf(input g, input e);
        chkv({15'h0000, g}, {15'h0000, e});
    endtask
    function [7:0] exp_vec(input [2:0] s, input a, input [2:0] l,
        input sp, input un, input [7:0] e);
        if (s == 3'h0) exp_vec = 8'h00;
        else if (s <= 3'h5) exp_vec = {5'h00, s} + 8'h03;
        else if (s == 3'h7) exp_vec = 8'h07;
        else if (sp) exp_vec = 8'h18;
        else if (un) exp_vec = 8'h0F;
        else if (a) exp_vec = (l == 3'h0) ? 8'h18 : 8'h10 + {5'h00, l};
        else exp_vec = e;
    endfunction
    function exp_rsv(input [7:0] v);
        exp_rsv = (v <= 8'h03) || (v >= 8'h19 && v <= 8'h37)
            || (v >= 8'h09 && v <= 8'h10 && v != 8'h0F);
    endfunction
    task wait_handler;
        integer k;
        begin
            k = 0;
            while (handlerStart !== 1'h1 && k < 40) begin
                @(posedge ref_clk);
                #1;
                k = k + 1;
            end
            chkf(handlerStart, 1'h1);
        end
    endtask
    task chk_reset;
        reg [15:0] w;
        begin
            w = tbl.mem_word(20'h00000, 1'h1);
            chkf(resetLoaded, 1'h1);
            chkv(zIndexBankField, w[11:8]);
            chkv(stackBankField, w[7:4]);
            chkv(programBankField, w[3:0]);
            chkv(pcOut, tbl.mem_word(20'h00002, 1'h1));
            chkv(spOut, tbl.mem_word(20'h00004, 1'h1));
            chkv(zIndexRegister, tbl.mem_word(20'h00006, 1'h1));
        end
    endtask
    task run_exc(input [2:0] s, input a, input [2:0] l, input sp,
        input un, input [7:0] e);
        reg [7:0] v;
        begin
            v = exp_vec(s, a, l, sp, un, e);
            @(posedge ref_clk);
            excReq <= 1'h1;
            excSource <= s;
            irqAutovector <= a;
            irqLevel <= l;
            irqSpurious <= sp;
            irqUninit <= un;
            extVectorNum <= e;
            ackDelay <= 2'($urandom_range(3));
            @(posedge ref_clk);
            excReq <= 1'h0;
            #1;
            chkv(vecNumOut, v);
            chkf(userFlag, v >= 8'h38);
            chkf(reservedFlag, s != 3'h0 && exp_rsv(v));
            wait_handler;
            if (s == 3'h0) chk_reset;
            else begin
                chkv(pcOut, tbl.mem_word({11'h000, v, 1'h0}, 1'h0));
                chkv(programBankField, 4'h0);
            end
            @(posedge ref_clk);
            #1;
            chkf(busy, 1'h0);
        end
    endtask
    task final_report;
        begin
            $display("Comparisons %0d, mismatches %0d", cmp_count, n_mismatch);
            if (n_mismatch == 0 && cmp_count > 0) $display("NO MISMATCHES");
            else $display("MISMATCHES SEEN");
            $finish;
        end
    endtask
    ////////////////////////////////////////////////////////////////////
    initial begin
        ref_clk = 1'h0;
        forever #2.5 ref_clk = ~ref_clk;
    end
    initial begin
        #100000;
        n_mismatch = n_mismatch + 1;
        final_report;
    end
    initial begin
        n_mismatch = 0;
        cmp_count = 0;
        {sys_rst, excReq, irqAutovector, irqSpurious, irqUninit} = 5'h10;
        {excSource, irqLevel, extVectorNum, ackDelay} = 16'h0000;
        i = $urandom(32'h550B2C57);
        repeat (8) @(posedge ref_clk);
        sys_rst <= 1'h0;
        wait_handler;
        chk_reset;
        for (i = 1; i <= 7; i = i + 1) run_exc(i[2:0], 0, 0, 0, 0, 0);
        for (i = 0; i < 8; i = i + 1) run_exc(6, 1, i[2:0], 0, 0, 0);
        run_exc(6, 0, 0, 0, 1, 8'h44);
        run_exc(6, 1, 3, 1, 0, 8'h44);
        for (i = 0; i < 9; i = i + 1) run_exc(6, 0, 0, 0, 0, corners[i*8 +: 8]);
        repeat (40) run_exc(6, 0, 0, 0, 0, 8'($urandom));
        run_exc(0, 0, 0, 0, 0, 0);
        final_report;
    end
endmodule
